/* File: logic/apil_alarm_panel_indicator_logic.sv */
// faceplate lamp drive and environmental contact logic for the alarm card
`timescale 1ns/1ps
`default_nettype none
`include "apil_defs.svh"
module apil_alarm_panel_indicator_logic #(
   parameter int unsigned BLINK_HALF_CYC = `APIL_BLINK_HALF_MS * `APIL_CLK_KHZ
) (
   input wire logic clock,                         // card clock, 125 MHz
   input wire logic reset_n,                       // async card reset, active low
   input wire logic cardInReset,                   // card held in reset
   input wire logic procBooting,                   // processor boot in progress
   input wire logic procReady,                     // processor ready
   input wire logic provisioned,                   // card provisioned for operation
   input wire logic supplyAOk,                     // supply input A in range
   input wire logic supplyBOk,                     // supply input B in range
   input wire logic localCallDet,                  // call seen on local orderwire
   input wire logic expressCallDet,                // call seen on express_orderwire
   input wire logic expansionPresent,              // alarm_expansion_panel fitted
   input wire logic [31:0] contactIn,              // contact state, 1 = closed
   input wire logic [31:0] inPolarity,             // 1 = alarm on closure
   input wire logic [3:0] cfgDirOut,               // configurable contact, 1 = output
   input wire logic [15:0] outTrigger,             // provisioned trigger per output
   input wire logic [15:0] outForceEn,             // manual operation per output
   input wire logic [15:0] outForceClose,          // manual level, 1 = close
   output logic failLamp,                          // red failure lamp
   output logic actLamp,                           // green activity lamp
   output apil_pkg::apil_lamp2_s supplyALamp,      // supply_a_lamp green/red
   output apil_pkg::apil_lamp2_s supplyBLamp,      // supply_b_lamp green/red
   output logic inputLamp,                         // amber input lamp
   output logic outputLamp,                        // amber output lamp
   output logic localRingLamp,                     // local ring lamp
   output logic expressRingLamp,                   // express ring lamp
   output logic [31:0] alarmIn,                    // per-input alarm state
   output logic [15:0] contactOutClose,            // per-output close command
   output logic [15:0] contactOutDrive             // output in use (enable)
);
   logic blinkTick;
   logic blinkPhase_ff;
   apil_pkg::apil_fail_e failState_ff;
   apil_pkg::apil_fail_e nxt_failState;
   logic nxt_failLamp;
   logic [31:0] inMask;
   logic [15:0] outMask;
   logic [31:0] nxt_alarmIn;
   logic [15:0] nxt_outClose;

   // one divider for every blinking lamp keeps them in step
   apil_blink_div #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_div (
      .clock(clock),
      .reset_n(reset_n),
      .blinkTick(blinkTick)
   );

   // blink phase toggles on each divider tick
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         blinkPhase_ff <= 1'h0;
      end else if (blinkTick) begin
         blinkPhase_ff <= ~blinkPhase_ff;
      end
   end

   // processor condition, reset has highest priority
   always_comb begin
      if (cardInReset) begin
         nxt_failState = apil_pkg::APIL_F_HELD;
      end else if (procBooting) begin
         nxt_failState = apil_pkg::APIL_F_BOOT;
      end else if (!procReady) begin
         nxt_failState = apil_pkg::APIL_F_DOWN;
      end else begin
         nxt_failState = apil_pkg::APIL_F_UP;
      end
   end

   // lamp decoded from the next state so it follows the inputs in one cycle
   always_comb begin
      case (nxt_failState)
         apil_pkg::APIL_F_HELD: nxt_failLamp = 1'h1;
         apil_pkg::APIL_F_BOOT: nxt_failLamp = blinkPhase_ff;
         apil_pkg::APIL_F_DOWN: nxt_failLamp = 1'h1;
         apil_pkg::APIL_F_UP: nxt_failLamp = 1'h0;
         default: nxt_failLamp = 1'h1;
      endcase
   end

   // failure lamp register; lit from reset so a dead card never looks healthy
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         failState_ff <= apil_pkg::APIL_F_HELD;
         failLamp <= `APIL_FAIL_RST;
      end else begin
         failState_ff <= nxt_failState;
         failLamp <= nxt_failLamp;
      end
   end

   // activity and supply lamps
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         actLamp <= `APIL_LAMP_OFF;
         supplyALamp <= '0;
         supplyBLamp <= '0;
      end else begin
         actLamp <= provisioned;
         supplyALamp.green <= supplyAOk;
         supplyALamp.red <= ~supplyAOk;
         supplyBLamp.green <= supplyBOk;
         supplyBLamp.red <= ~supplyBOk;
      end
   end

   // ring lamps blink only while a call is detected, each on its own
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         localRingLamp <= `APIL_LAMP_OFF;
         expressRingLamp <= `APIL_LAMP_OFF;
      end else begin
         localRingLamp <= localCallDet & blinkPhase_ff;
         expressRingLamp <= expressCallDet & blinkPhase_ff;
      end
   end

   // per-input mask and polarity; contacts 12..15 double as outputs 0..3
   genvar gi;
   generate
      for (gi = 0; gi < `APIL_MAX_INPUTS; gi = gi + 1) begin : g_in
         if (gi < `APIL_DED_INPUTS) begin : g_ded
            assign inMask[gi] = 1'h1;
         end else if (gi < `APIL_CFG_BASE + `APIL_CFG_CONTACTS) begin : g_cfg
            assign inMask[gi] = expansionPresent | ~cfgDirOut[gi - `APIL_CFG_BASE];
         end else begin : g_exp
            assign inMask[gi] = expansionPresent;
         end
         assign nxt_alarmIn[gi] = inMask[gi] & (contactIn[gi] == inPolarity[gi]);
      end
   endgenerate

   // per-output mask and manual override
   genvar go;
   generate
      for (go = 0; go < `APIL_MAX_OUTPUTS; go = go + 1) begin : g_out
         if (go < `APIL_CFG_CONTACTS) begin : g_cfg
            assign outMask[go] = expansionPresent | cfgDirOut[go];
         end else begin : g_exp
            assign outMask[go] = expansionPresent;
         end
         // manual setting wins so a craftsperson can always silence a bell
         assign nxt_outClose[go] = outMask[go] &
            (outForceEn[go] ? outForceClose[go] : outTrigger[go]);
      end
   endgenerate

   // contact states and aggregate lamps registered together, so they agree
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alarmIn <= 32'h0;
         contactOutClose <= 16'h0;
         contactOutDrive <= 16'h0;
         inputLamp <= `APIL_LAMP_OFF;
         outputLamp <= `APIL_LAMP_OFF;
      end else begin
         alarmIn <= nxt_alarmIn;
         contactOutClose <= nxt_outClose;
         contactOutDrive <= outMask;
         inputLamp <= |nxt_alarmIn;
         outputLamp <= |nxt_outClose;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   property p_fail_held;
      cardInReset |=> failLamp;
   endproperty
   a_fail_held: assert property (p_fail_held) else $error("fail lamp dark in reset");

   property p_fail_up;
      (!cardInReset && !procBooting && procReady) |=> !failLamp;
   endproperty
   a_fail_up: assert property (p_fail_up) else $error("fail lamp lit when ready");

   property p_fail_boot;
      (!cardInReset && procBooting) |=> (failLamp == $past(blinkPhase_ff));
   endproperty
   a_fail_boot: assert property (p_fail_boot) else $error("fail lamp not blinking");

   // registered condition and lamp are loaded on the same edge, so steady states must agree
   property p_fail_state;
      (failState_ff != apil_pkg::APIL_F_BOOT) |-> (failLamp == (failState_ff != apil_pkg::APIL_F_UP));
   endproperty
   a_fail_state: assert property (p_fail_state) else $error("fail lamp disagrees with state");

   property p_act;
      1'b1 |=> (actLamp == $past(provisioned));
   endproperty
   a_act: assert property (p_act) else $error("activity lamp wrong");

   property p_supply_a;
      !supplyAOk |=> (supplyALamp.red && !supplyALamp.green);
   endproperty
   a_supply_a: assert property (p_supply_a) else $error("supply A lamp not red");

   property p_supply_b;
      supplyBOk |=> (supplyBLamp.green && !supplyBLamp.red);
   endproperty
   a_supply_b: assert property (p_supply_b) else $error("supply B lamp not green");

   property p_in_lamp;
      inputLamp == (|alarmIn);
   endproperty
   a_in_lamp: assert property (p_in_lamp) else $error("input lamp disagrees");

   property p_out_lamp;
      outputLamp == (|contactOutClose);
   endproperty
   a_out_lamp: assert property (p_out_lamp) else $error("output lamp disagrees");

   property p_ring_local;
      !localCallDet |=> !localRingLamp;
   endproperty
   a_ring_local: assert property (p_ring_local) else $error("local ring lit, no call");

   property p_ring_express;
      expressCallDet |=> (expressRingLamp == $past(blinkPhase_ff));
   endproperty
   a_ring_express: assert property (p_ring_express) else $error("express ring wrong");

   property p_no_panel;
      !expansionPresent |=> (!alarmIn[20] && !contactOutClose[9]);
   endproperty
   a_no_panel: assert property (p_no_panel) else $error("panel contact used");

   property p_polarity;
      (expansionPresent && contactIn[31] == inPolarity[31]) |=> alarmIn[31];
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity alarm missed");

   property p_force;
      (expansionPresent && outForceEn[15]) |=> (contactOutClose[15] == $past(outForceClose[15]));
   endproperty
   a_force: assert property (p_force) else $error("manual force ignored");

endmodule
`default_nettype wire

/* File: logic/apil_blink_div.sv */
// blink rate divider: one-cycle tick every half blink period
`timescale 1ns/1ps
`default_nettype none
module apil_blink_div #(
   parameter int unsigned HALF_CYC = 32'd31250000
) (
   input wire logic clock,      // card clock
   input wire logic reset_n,    // async reset, active low
   output logic blinkTick       // one-cycle enable pulse
);
   logic [31:0] cnt_ff;

   // free-running count; wraps so the tick spacing is exactly HALF_CYC
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 32'h0;
         blinkTick <= 1'h0;
      end else if (cnt_ff == 32'(HALF_CYC - 1)) begin
         cnt_ff <= 32'h0;
         blinkTick <= 1'h1;
      end else begin
         cnt_ff <= cnt_ff + 32'h1;
         blinkTick <= 1'h0;
      end
   end
endmodule
`default_nettype wire

/* File: logic/apil_defs.svh */
// constants for the alarm panel indicator logic: counts, offsets, timing, reset values
`ifndef APIL_DEFS_SVH
`define APIL_DEFS_SVH

`define APIL_CLK_KHZ 125000
`define APIL_BLINK_HALF_MS 250
`define APIL_DED_INPUTS 12
`define APIL_CFG_CONTACTS 4
`define APIL_CFG_BASE 12
`define APIL_MAX_INPUTS 32
`define APIL_MAX_OUTPUTS 16
`define APIL_FAIL_RST 1'h1
`define APIL_LAMP_OFF 1'h0

`endif

/* File: logic/apil_pkg.sv */
// types shared by the alarm panel indicator logic
package apil_pkg;

   // two-colour lamp drive, green and red legs
   typedef struct packed {
      logic green;
      logic red;
   } apil_lamp2_s;

   // card processor condition as seen by the failure lamp
   typedef enum logic [3:0] {
      APIL_F_HELD = 4'h1,
      APIL_F_BOOT = 4'h2,
      APIL_F_DOWN = 4'h4,
      APIL_F_UP = 4'h8
   } apil_fail_e;

endpackage

/* File: verification/apil_alarm_panel_indicator_logic_tb.sv */
// self-checking bench for the alarm panel indicator logic
`timescale 1ns/1ps
`default_nettype none
module apil_alarm_panel_indicator_logic_tb;
   logic clock, reset_n, cardInReset, procBooting, procReady, provisioned;
   logic supplyAOk, supplyBOk, localCallDet, expressCallDet, expansionPresent;
   logic [31:0] contactIn, inPolarity, alarmIn;
   logic [3:0] cfgDirOut;
   logic [15:0] outTrigger, outForceEn, outForceClose;
   logic [15:0] contactOutClose, contactOutDrive, relayClosed;
   logic failLamp, actLamp, inputLamp, outputLamp, localRingLamp, expressRingLamp;
   apil_pkg::apil_lamp2_s supplyALamp, supplyBLamp;
   int miscompares, tests_run, cycles, hl, he, hf;
   // rows: reset, boot, ready, provisioned, supply A, supply B | fail, act, A g/r, B g/r
   logic [11:0] rows [4] = '{12'b001111_011010, 12'b101010_101001,
                             12'b000101_110110, 12'b001000_000101};

   // short blink period keeps the run brief
   apil_alarm_panel_indicator_logic #(.BLINK_HALF_CYC(4)) dut (.clock, .reset_n,
      .cardInReset, .procBooting, .procReady, .provisioned, .supplyAOk, .supplyBOk,
      .localCallDet, .expressCallDet, .expansionPresent, .contactIn, .inPolarity,
      .cfgDirOut, .outTrigger, .outForceEn, .outForceClose, .failLamp, .actLamp,
      .supplyALamp, .supplyBLamp, .inputLamp, .outputLamp, .localRingLamp,
      .expressRingLamp, .alarmIn, .contactOutClose, .contactOutDrive);
   apil_relay_model relays (.closeCmd(contactOutClose), .driveEn(contactOutDrive),
      .relayClosed(relayClosed));

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // a hang is cut short well past the expected length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 500) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      reset_n = 1'b0;
      {cardInReset, procBooting, procReady, provisioned, supplyAOk, supplyBOk, localCallDet,
         expressCallDet, expansionPresent, contactIn, inPolarity, cfgDirOut, outTrigger,
         outForceEn, outForceClose} = '0;
      repeat (12) @(negedge clock);
      chk({failLamp, actLamp, supplyALamp, supplyBLamp}, 6'h20);
      reset_n = 1'b1;
      // lamp table, inputs applied one edge before the check
      foreach (rows[i]) begin
         {cardInReset, procBooting, procReady, provisioned, supplyAOk, supplyBOk} = rows[i][11:6];
         @(negedge clock);
         chk({failLamp, actLamp, supplyALamp, supplyBLamp}, rows[i][5:0]);
      end
      // no panel: contacts 12 and 14 turned to outputs 0 and 2, all open
      cfgDirOut = 4'h5;
      outTrigger = 16'hFFFF;
      @(negedge clock);
      chk(alarmIn, 32'h0000AFFF);
      chk({inputLamp, outputLamp}, 2'h3);
      chk({contactOutClose, contactOutDrive}, 32'h00050005);
      outForceEn = 16'h0001;
      @(negedge clock);
      chk(relayClosed, 16'h0004);
      inPolarity = 32'hFFFFFFFF;
      outTrigger = 16'h0000;
      contactIn = 32'h80001800;
      @(negedge clock);
      chk(alarmIn, 32'h00000800);
      contactIn = 32'h80001000;
      @(negedge clock);
      chk({alarmIn[31:0], inputLamp, outputLamp}, 34'h0);
      // panel fitted: every contact in use, manual open on output 0 wins over the trigger, manual close on output 15 matches it
      expansionPresent = 1'b1;
      outTrigger = 16'hFFFF;
      outForceEn = 16'h8001;
      outForceClose = 16'h8000;
      @(negedge clock);
      chk(alarmIn, 32'h80001000);
      chk({contactOutClose, contactOutDrive}, 32'hFFFEFFFF);
      chk({inputLamp, outputLamp}, 2'h3);
      // booting and calls: lit half of every sixteen cycles, the idle lamp stays dark
      for (int k = 0; k < 2; k++) begin
         {procBooting, localCallDet, expressCallDet} = (k == 0) ? 3'h6 : 3'h5;
         @(negedge clock);
         {hl, he, hf} = '0;
         repeat (16) begin
            @(negedge clock);
            hl += localRingLamp;
            he += expressRingLamp;
            hf += failLamp;
         end
         chk(hf, 8);
         chk(hl, (k == 0) ? 8 : 0);
         chk(he, (k == 0) ? 0 : 8);
      end
      // reset in mid-run takes effect without a clock edge
      reset_n = 1'b0;
      #1;
      chk({alarmIn, contactOutClose, contactOutDrive}, 64'h0);
      chk({failLamp, actLamp, supplyALamp, supplyBLamp, inputLamp, outputLamp,
         localRingLamp, expressRingLamp}, 10'h200);
      // release again: blink phase restarts dark, contacts follow inputs at once
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      chk({failLamp, actLamp, expressRingLamp}, 3'h0);
      chk(alarmIn, 32'h80001000);
      @(negedge clock);
      chk({inputLamp, outputLamp, failLamp}, 3'h6);
      end_of_test();
   end
endmodule
`default_nettype wire

/* File: verification/apil_relay_model.sv */
// relay contacts standing behind the control outputs
`timescale 1ns/1ps
`default_nettype none
module apil_relay_model (
   input wire logic [15:0] closeCmd, // close command per output
   input wire logic [15:0] driveEn,  // output in use
   output logic [15:0] relayClosed   // contact closed
);
   // an undriven relay springs back open, it never keeps the last command
   assign relayClosed = closeCmd & driveEn;
endmodule
`default_nettype wire
